// ---- include/ffb_defines.svh ----
// Register offsets, bit layouts, reset values and timing counts of the fault flag bank.
`ifndef FFB_DEFINES_SVH
`define FFB_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FFB_LIVE0_ADDR 8'h07
`define FFB_SW_FLAGS_ADDR 8'h08
`define FFB_SW_MASKS_ADDR 8'h09
`define FFB_SW_LIVE_ADDR 8'h0a
`define FFB_BF_FLAGS_ADDR 8'h0e
`define FFB_BF_MASKS_ADDR 8'h0f
`define FFB_BF_LIVE_ADDR 8'h10
`define FFB_LIN_FLAGS_ADDR 8'h11
`define FFB_LIN_MASKS_ADDR 8'h12
`define FFB_LIN_LIVE_ADDR 8'h13

// ----------------------------------------------------------------
// Implemented bits and reset values
// ----------------------------------------------------------------
`define FFB_SW_IMPL 8'h1b
`define FFB_BF_IMPL 8'hc1
`define FFB_LIN_IMPL 8'h3f
`define FFB_SW_MASK_RST 8'h1b
`define FFB_BF_MASK_RST 8'hc1
`define FFB_LIN_MASK_RST 8'h3f
`define FFB_FLAGS_RST 8'h00
`define FFB_BLOW_BIT 6
`define FFB_ERR_BIT 7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FFB_CLK_PERIOD_NS 25
`define FFB_OC_DBNC_NS 8000000
`define FFB_EN_DBNC_NS 31250000
`define FFB_OC_DBNC_CYC ((`FFB_OC_DBNC_NS + `FFB_CLK_PERIOD_NS - 1) / `FFB_CLK_PERIOD_NS)
`define FFB_EN_DBNC_CYC ((`FFB_EN_DBNC_NS + `FFB_CLK_PERIOD_NS - 1) / `FFB_CLK_PERIOD_NS)
`define FFB_CNT_W 24
`define FFB_OC_N 10

`endif

// ---- include/ffb_pkg.sv ----
// Types shared by the fault flag bank and its neighbours.
package ffb_pkg;

	// Register port request from the serial control interface.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ffb_reg_req_s;

	// Raw analog comparator and pin levels, asynchronous to clk_i.
	typedef struct packed {
		logic en_pin;
		logic fuse_supply_pin;
		logic test_pin;
		logic temp_high3;
		logic temp_high2;
		logic [5:0] lin_oc;
		logic boost_oc;
		logic [2:0] buck_oc;
	} ffb_raw_s;

endpackage

// ---- rtl/ffb_flag_bank.sv ----
// Fault event flag bank: debounced sources, sticky flags, masks, live view and interrupt.
// How it works
// R1: Switcher flags at 0x08, bits 0,1,3,4, W1C.
// R2: Switcher masks at 0x09, reset to masked.
// R3: Switcher live bits at 0x0a, read only.
// R4: Boost, auto-blow done, memory error flags at 0x0e.
// R5: Their masks at 0x0f, reset to one.
// R6: Live bit 6 shows auto-blow in progress.
// R7: Processor avoids fuse registers while blow busy.
// R8: Live bit 7 shows memory error detected.
// R9: Live bit 0 shows boost overcurrent.
// R10: Linear regulator flags at 0x11, bits 0-5.
// R11: Linear masks at 0x12, reset one, 7:6 zero.
// R12: Linear live bits at 0x13, same order.
// R13: Live bank 0 bits 4,5 show temperature.
// R14: Live bank 0 bit 6 shows test pin.
// R15: Live bank 0 bit 7 shows fuse supply.
// R16: Selector extends power-on falling debounce time.
// R17: Flags stay latched until written with one.
// R18: Interrupt low while any unmasked flag set.
// R19: Unmasking a set flag asserts interrupt; masked readable.
// R20: Sources set flags only after 8.0 ms stable.
// R21: Unused bits read zero; writing zero keeps flags.
// R22: Debounced rising edge sets; set beats clear.
`timescale 1ns/1ps
`include "ffb_defines.svh"

module ffb_flag_bank #(
	parameter int unsigned OC_DBNC_CYC = `FFB_OC_DBNC_CYC,
	parameter int unsigned EN_DBNC_CYC = `FFB_EN_DBNC_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire ffb_pkg::ffb_reg_req_s reg_req_i,
	input wire ffb_pkg::ffb_raw_s raw_i,
	input wire logic fuse_blow_busy_i,
	input wire logic fuse_mem_err_i,
	input wire logic [1:0] power_on_debounce_sel_i,
	output logic [7:0] reg_rdata_o,
	output logic irq_n_out_o,
	output logic en_debounced_o
);
	import ffb_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] ffb_w1c(input logic [7:0] flags, input logic [7:0] set,
		input logic hit, input logic [7:0] wdata, input logic [7:0] impl);
		logic [7:0] clr;
		clr = hit ? wdata : 8'h00;
		ffb_w1c = ((flags & ~clr) | set) & impl;
	endfunction

	function automatic logic [7:0] ffb_rw(input logic [7:0] cur, input logic hit,
		input logic [7:0] wdata, input logic [7:0] impl);
		ffb_rw = hit ? (wdata & impl) : cur;
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	ffb_raw_s sync1_q;
	ffb_raw_s sync2_q;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= raw_i;
			sync2_q <= sync1_q;
		end
	end

	// ----------------------------------------------------------------
	// Overcurrent debounce
	// ----------------------------------------------------------------
	// Order: buck1..3, boost, lin1, lin2, card, reg33, lin3, lin4.
	logic [`FFB_OC_N-1:0] oc_live;
	logic [`FFB_OC_N-1:0] oc_db_q;
	logic [`FFB_OC_N-1:0] oc_set;
	logic [`FFB_CNT_W-1:0] oc_cnt_q [`FFB_OC_N];
	localparam logic [`FFB_CNT_W-1:0] OC_LAST = `FFB_CNT_W'(OC_DBNC_CYC - 1);

	assign oc_live = {sync2_q.lin_oc, sync2_q.boost_oc, sync2_q.buck_oc};

	// A source must hold its new level for the whole period before the
	// debounced copy follows; any glitch back restarts the count.
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < `FFB_OC_N; i++) begin
			if (!rst_n_i) begin
				oc_cnt_q[i] <= '0;
				oc_db_q[i] <= 1'b0;
			end else if (oc_live[i] == oc_db_q[i]) begin
				oc_cnt_q[i] <= '0;
			end else if (oc_cnt_q[i] >= OC_LAST) begin // see R20
				oc_cnt_q[i] <= '0;
				oc_db_q[i] <= oc_live[i];
			end else begin
				oc_cnt_q[i] <= oc_cnt_q[i] + 1'b1;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < `FFB_OC_N; i++) begin
			oc_set[i] = oc_live[i] & ~oc_db_q[i] & (oc_cnt_q[i] >= OC_LAST); // see R22
		end
	end

	// ----------------------------------------------------------------
	// Power-on pin debounce
	// ----------------------------------------------------------------
	logic [`FFB_CNT_W-1:0] en_cnt_q;
	logic [`FFB_CNT_W-1:0] en_last;

	// The falling edge limit doubles per selector step, up to eight times.
	always_comb begin
		if (en_debounced_o) begin
			en_last = `FFB_CNT_W'(EN_DBNC_CYC) << power_on_debounce_sel_i; // see R16
		end else begin
			en_last = `FFB_CNT_W'(EN_DBNC_CYC);
		end
		en_last = en_last - 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			en_cnt_q <= '0;
			en_debounced_o <= 1'b0;
		end else if (sync2_q.en_pin == en_debounced_o) begin
			en_cnt_q <= '0;
		end else if (en_cnt_q >= en_last) begin
			en_cnt_q <= '0;
			en_debounced_o <= sync2_q.en_pin;
		end else begin
			en_cnt_q <= en_cnt_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Fuse memory events
	// ----------------------------------------------------------------
	logic blow_busy_q;
	logic mem_err_q;
	logic blow_done;
	logic err_rise;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			blow_busy_q <= 1'b0;
			mem_err_q <= 1'b0;
		end else begin
			blow_busy_q <= fuse_blow_busy_i;
			mem_err_q <= fuse_mem_err_i;
		end
	end

	// Completion is the end of the busy window.
	assign blow_done = blow_busy_q & ~fuse_blow_busy_i; // see R4
	assign err_rise = fuse_mem_err_i & ~mem_err_q; // see R4

	// ----------------------------------------------------------------
	// Flags and masks
	// ----------------------------------------------------------------
	logic [7:0] sw_flags_q, sw_flags_d, sw_masks_q, sw_masks_d;
	logic [7:0] bf_flags_q, bf_flags_d, bf_masks_q, bf_masks_d;
	logic [7:0] lin_flags_q, lin_flags_d, lin_masks_q, lin_masks_d;
	logic [7:0] sw_set, bf_set, lin_set;
	logic wr;

	assign wr = reg_req_i.wr;
	// Buck 1 drives both of its flag bits.
	assign sw_set = {3'b000, oc_set[2], oc_set[1], 1'b0, oc_set[0], oc_set[0]}; // see R1
	assign bf_set = {err_rise, blow_done, 5'b00000, oc_set[3]}; // see R4
	assign lin_set = {2'b00, oc_set[9:4]}; // see R10

	always_comb begin
		sw_flags_d = ffb_w1c(sw_flags_q, sw_set, wr && reg_req_i.addr == `FFB_SW_FLAGS_ADDR,
			reg_req_i.wdata, `FFB_SW_IMPL); // see R1, R17, R21, R22
		bf_flags_d = ffb_w1c(bf_flags_q, bf_set, wr && reg_req_i.addr == `FFB_BF_FLAGS_ADDR,
			reg_req_i.wdata, `FFB_BF_IMPL); // see R4, R17, R22
		lin_flags_d = ffb_w1c(lin_flags_q, lin_set, wr && reg_req_i.addr == `FFB_LIN_FLAGS_ADDR,
			reg_req_i.wdata, `FFB_LIN_IMPL); // see R10, R17, R22
		sw_masks_d = ffb_rw(sw_masks_q, wr && reg_req_i.addr == `FFB_SW_MASKS_ADDR,
			reg_req_i.wdata, `FFB_SW_IMPL); // see R2
		bf_masks_d = ffb_rw(bf_masks_q, wr && reg_req_i.addr == `FFB_BF_MASKS_ADDR,
			reg_req_i.wdata, `FFB_BF_IMPL); // see R5
		lin_masks_d = ffb_rw(lin_masks_q, wr && reg_req_i.addr == `FFB_LIN_MASKS_ADDR,
			reg_req_i.wdata, `FFB_LIN_IMPL); // see R11
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sw_flags_q <= `FFB_FLAGS_RST;
			bf_flags_q <= `FFB_FLAGS_RST;
			lin_flags_q <= `FFB_FLAGS_RST;
		end else begin
			sw_flags_q <= sw_flags_d;
			bf_flags_q <= bf_flags_d;
			lin_flags_q <= lin_flags_d;
		end
	end

	// The part starts fully masked so software must opt in.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sw_masks_q <= `FFB_SW_MASK_RST; // see R2
			bf_masks_q <= `FFB_BF_MASK_RST; // see R5
			lin_masks_q <= `FFB_LIN_MASK_RST; // see R11
		end else begin
			sw_masks_q <= sw_masks_d;
			bf_masks_q <= bf_masks_d;
			lin_masks_q <= lin_masks_d;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------
	logic pending_d;

	// Built from next-state values so a mask write or a new event shows on
	// the pin at the same edge that updates the registers.
	assign pending_d = |((sw_flags_d & ~sw_masks_d) | (bf_flags_d & ~bf_masks_d) |
		(lin_flags_d & ~lin_masks_d));

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_n_out_o <= 1'b1;
		end else begin
			irq_n_out_o <= ~pending_d; // see R18, R19
		end
	end

	// ----------------------------------------------------------------
	// Live views and read port
	// ----------------------------------------------------------------
	logic [7:0] live0, sw_live, bf_live, lin_live;
	logic [7:0] rdata_d;

	assign live0 = {sync2_q.fuse_supply_pin, sync2_q.test_pin, sync2_q.temp_high3,
		sync2_q.temp_high2, 4'h0}; // see R13, R14, R15
	assign sw_live = {3'b000, oc_live[2], oc_live[1], oc_live[0], 1'b0, oc_live[0]}; // see R3
	assign bf_live = {fuse_mem_err_i, fuse_blow_busy_i, 5'b00000, oc_live[3]}; // see R6, R8, R9
	assign lin_live = {2'b00, oc_live[9:4]}; // see R12

	always_comb begin
		case (reg_req_i.addr)
			`FFB_LIVE0_ADDR: rdata_d = live0;
			`FFB_SW_FLAGS_ADDR: rdata_d = sw_flags_q; // see R19
			`FFB_SW_MASKS_ADDR: rdata_d = sw_masks_q;
			`FFB_SW_LIVE_ADDR: rdata_d = sw_live;
			`FFB_BF_FLAGS_ADDR: rdata_d = bf_flags_q;
			`FFB_BF_MASKS_ADDR: rdata_d = bf_masks_q;
			`FFB_BF_LIVE_ADDR: rdata_d = bf_live;
			`FFB_LIN_FLAGS_ADDR: rdata_d = lin_flags_q;
			`FFB_LIN_MASKS_ADDR: rdata_d = lin_masks_q;
			`FFB_LIN_LIVE_ADDR: rdata_d = lin_live;
			default: rdata_d = 8'h00; // see R21
		endcase
	end

	// Read data is held until the next read strobe.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_req_i.rd) begin
			reg_rdata_o <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_set_beats_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R22
		oc_set[4] |=> lin_flags_q[0])
		else $error("linear 1 set lost");

	a_w1c_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R17
		(wr && reg_req_i.addr == `FFB_LIN_FLAGS_ADDR && reg_req_i.wdata[5] && !oc_set[9])
		|=> !lin_flags_q[5])
		else $error("flag not cleared by write one");

	a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R21
		(sw_flags_q[3] && !(wr && reg_req_i.addr == `FFB_SW_FLAGS_ADDR && reg_req_i.wdata[3]))
		|=> sw_flags_q[3])
		else $error("flag dropped without clear");

	a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R18
		##1 (irq_n_out_o == !(|((sw_flags_q & ~sw_masks_q) | (bf_flags_q & ~bf_masks_q) |
		(lin_flags_q & ~lin_masks_q)))))
		else $error("interrupt pin disagrees with flags");

	a_unmask_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R19
		(wr && reg_req_i.addr == `FFB_BF_MASKS_ADDR &&
		|(bf_flags_q & ~reg_req_i.wdata & `FFB_BF_IMPL)) |=> !irq_n_out_o)
		else $error("unmask did not raise interrupt");

	a_debounce_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R20
		$rose(oc_db_q[3]) |-> $past(oc_cnt_q[3]) == OC_LAST && $past(oc_live[3]))
		else $error("boost debounce too short");

	a_blow_done: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R4
		$fell(fuse_blow_busy_i) |=> bf_flags_q[`FFB_BLOW_BIT])
		else $error("auto-blow completion not flagged");

	a_mask_unused: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R11
		(lin_masks_q[7:6] == 2'b00) && (sw_masks_q[7:5] == 3'b000) && !sw_masks_q[2])
		else $error("unused mask bit set");

	a_read_live: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R6
		(reg_req_i.rd && reg_req_i.addr == `FFB_BF_LIVE_ADDR)
		|=> reg_rdata_o[`FFB_BLOW_BIT] == $past(fuse_blow_busy_i))
		else $error("busy live bit wrong");

	a_err_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R4
		$rose(fuse_mem_err_i) |=> bf_flags_q[`FFB_ERR_BIT])
		else $error("memory error not flagged");

endmodule

// ---- bench/ffb_host_model.sv ----
// Processor model: issues register reads and writes over the strobe port.
`timescale 1ns/1ps

module ffb_host_model (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output ffb_pkg::ffb_reg_req_s req_o
);
	import ffb_pkg::*;

	initial req_o = '0;

	// -------------------------------------------------------------
	// Access tasks
	// -------------------------------------------------------------
	// Each request is held across exactly one sampling edge.
	// This host never touches fuse setup registers, busy or not.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{1'b1, 1'b0, a, d};
		@(posedge clk_i);
		req_o <= '0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_i);
		req_o <= '0;
		#1 d = rdata_i;
	endtask
endmodule

// ---- bench/fault_event_flag_bank_tb_top.sv ----
// Self-checking bench for the fault flag bank.
`timescale 1ns/1ps

module fault_event_flag_bank_tb_top;
	import ffb_pkg::*;
	localparam int OC = 8;
	localparam int EN = 4;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	ffb_reg_req_s req;
	ffb_raw_s raw_q = '0;
	logic busy_q = 1'b0;
	logic err_q = 1'b0;
	logic [1:0] sel_q = 2'h0;
	logic [7:0] rdata;
	logic irq_n;
	logic en_dbn;
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;

	always #12.5 clk_i = ~clk_i;

	ffb_flag_bank #(.OC_DBNC_CYC(OC), .EN_DBNC_CYC(EN)) dut_u (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_req_i(req), .raw_i(raw_q),
		.fuse_blow_busy_i(busy_q), .fuse_mem_err_i(err_q),
		.power_on_debounce_sel_i(sel_q), .reg_rdata_o(rdata),
		.irq_n_out_o(irq_n), .en_debounced_o(en_dbn));

	ffb_host_model host_u (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host_u.rd(a, d);
		chk($sformatf("reg %h", a), d, exp);
	endtask

	// The delay lets the edge's updates land before the pin is sampled.
	task automatic ichk(input logic exp);
		#1 chk("irq", {7'h00, irq_n}, {7'h00, exp});
	endtask

	task automatic set_raw(input int i, input logic v);
		logic [$bits(ffb_raw_s)-1:0] rv;
		@(posedge clk_i);
		rv = raw_q;
		rv[i] = v;
		raw_q <= ffb_raw_s'(rv);
	endtask

	// Overcurrent sources 0..9 in raw order: three bucks, boost, six linears.
	function automatic logic [7:0] oc_addr(input int i, input logic live);
		if (i < 3) return live ? 8'h0a : 8'h08;
		if (i == 3) return live ? 8'h10 : 8'h0e;
		return live ? 8'h13 : 8'h11;
	endfunction

	function automatic logic [7:0] oc_bits(input int i, input logic live);
		if (i == 0) return live ? 8'h05 : 8'h03;
		if (i < 3) return 8'h01 << (i + 2);
		if (i == 3) return 8'h01;
		return 8'h01 << (i - 4);
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			test_done();
		end
	end

	// -------------------------------------------------------------
	// Tests
	// -------------------------------------------------------------
	initial begin
		int i;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rchk(8'h09, 8'h1b);
		rchk(8'h0f, 8'hc1);
		rchk(8'h12, 8'h3f);
		rchk(8'h08, 8'h00);
		rchk(8'h0e, 8'h00);
		rchk(8'h11, 8'h00);
		rchk(8'h05, 8'h00);
		ichk(1'b1);
		host_u.wr(8'h12, 8'hff);
		rchk(8'h12, 8'h3f);
		host_u.wr(8'h0f, 8'hff);
		rchk(8'h0f, 8'hc1);
		host_u.wr(8'h13, 8'hff);
		rchk(8'h13, 8'h00);
		$display("test reset done");
		host_u.wr(8'h09, 8'h00);
		host_u.wr(8'h12, 8'h00);
		host_u.wr(8'h0f, 8'hc0);
		rchk(8'h09, 8'h00);
		// A pulse shorter than the debounce window must leave no flag.
		set_raw(3, 1'b1);
		repeat (OC - 3) @(posedge clk_i);
		set_raw(3, 1'b0);
		repeat (OC + 6) @(posedge clk_i);
		rchk(8'h0e, 8'h00);
		for (i = 0; i < 10; i++) begin
			set_raw(i, 1'b1);
			repeat (OC + 6) @(posedge clk_i);
			rchk(oc_addr(i, 1'b1), oc_bits(i, 1'b1));
			rchk(oc_addr(i, 1'b0), oc_bits(i, 1'b0));
			ichk(1'b0);
			set_raw(i, 1'b0);
			repeat (OC + 6) @(posedge clk_i);
			host_u.wr(oc_addr(i, 1'b0), 8'h00);
			rchk(oc_addr(i, 1'b0), oc_bits(i, 1'b0));
			host_u.wr(oc_addr(i, 1'b0), oc_bits(i, 1'b0));
			rchk(oc_addr(i, 1'b0), 8'h00);
			ichk(1'b1);
		end
		$display("test overcurrent done");
		host_u.wr(8'h0f, 8'hc1);
		@(posedge clk_i);
		busy_q <= 1'b1;
		rchk(8'h10, 8'h40);
		@(posedge clk_i);
		busy_q <= 1'b0;
		rchk(8'h10, 8'h00);
		rchk(8'h0e, 8'h40);
		ichk(1'b1);
		host_u.wr(8'h0f, 8'h01);
		ichk(1'b0);
		fork
			host_u.wr(8'h0e, 8'h40);
			begin @(posedge clk_i); err_q <= 1'b1; end
		join
		ichk(1'b0);
		rchk(8'h10, 8'h80);
		rchk(8'h0e, 8'h80);
		@(posedge clk_i);
		err_q <= 1'b0;
		fork
			host_u.wr(8'h0e, 8'h80);
			begin @(posedge clk_i); err_q <= 1'b1; end
		join
		rchk(8'h0e, 8'h80);
		host_u.wr(8'h0e, 8'h80);
		rchk(8'h0e, 8'h00);
		ichk(1'b1);
		$display("test fuse done");
		for (i = 10; i < 14; i++) begin
			set_raw(i, 1'b1);
			repeat (3) @(posedge clk_i);
			rchk(8'h07, 8'h01 << (i - 6));
			set_raw(i, 1'b0);
		end
		$display("test pins done");
		set_raw(14, 1'b1);
		repeat (EN + 6) @(posedge clk_i);
		#1 chk("en", {7'h00, en_dbn}, 8'h01);
		@(posedge clk_i);
		sel_q <= 2'h3;
		set_raw(14, 1'b0);
		repeat (EN * 5) @(posedge clk_i);
		#1 chk("en", {7'h00, en_dbn}, 8'h01);
		repeat (EN * 5) @(posedge clk_i);
		#1 chk("en", {7'h00, en_dbn}, 8'h00);
		// Selector step 1 doubles the falling limit: still high where 1x would have dropped.
		@(posedge clk_i);
		sel_q <= 2'h1;
		set_raw(14, 1'b1);
		repeat (EN + 6) @(posedge clk_i);
		set_raw(14, 1'b0);
		repeat (EN + 2) @(posedge clk_i);
		#1 chk("en", {7'h00, en_dbn}, 8'h01);
		repeat (EN + 2) @(posedge clk_i);
		#1 chk("en", {7'h00, en_dbn}, 8'h00);
		$display("test debounce done");
		test_done();
	end
endmodule
